// File: rxp_pkg.sv
// ============================================================
// shared constants for the per-port interrupt status block
package rxp_pkg;

  localparam int NUM_PORTS = 4;                  // receive ports behind the port-select register
  localparam int PORT_W    = 2;                  // width of a port index
  localparam int GPIO_N    = 4;                  // forward-channel gpios per port

  // ============================================================
  // register offsets
  localparam logic [7:0] ADDR_PORT_SEL  = 8'h4C; // port-select register
  localparam logic [7:0] ADDR_ERR_EN    = 8'hD8; // link_error_irq_enable
  localparam logic [7:0] ADDR_VID_EN    = 8'hD9; // video_irq_enable
  localparam logic [7:0] ADDR_ERR_STS   = 8'hDA; // port_link_error_irq_status
  localparam logic [7:0] ADDR_VID_STS   = 8'hDB; // port_video_irq_status
  localparam logic [7:0] ADDR_GPIO_STS  = 8'hDC; // forward_gpio_status
  localparam logic [7:0] ADDR_GPIO_IE   = 8'hDD; // gpio_edge_irq_enable

  // ============================================================
  // reset values
  localparam logic [7:0] RST_BYTE       = 8'h00; // status and enable registers
  localparam logic [7:0] RST_PORT_SEL   = 8'h01; // port 0 written and read after reset

  // ============================================================
  // port-select field layout
  localparam int PSEL_WR_LSB = 0;                // one write-enable bit per port
  localparam int PSEL_RD_LSB = 4;                // index of the port that reads see

  // ============================================================
  // link-error status bits
  localparam int BIT_ENC = 2;                    // encode_error_irq_flag
  localparam int BIT_SEQ = 1;                    // ctrl_channel_sequence_irq_flag
  localparam int BIT_CRC = 0;                    // ctrl_channel_crc_irq_flag
  localparam logic [7:0] ERR_MASK      = 8'h07;  // implemented link-error bits
  localparam logic [7:0] ERR_STS1_CLR  = 8'h03;  // cleared by reading link_status_one
  localparam logic [7:0] ERR_STS2_CLR  = 8'h04;  // cleared by reading link_status_two

  // ============================================================
  // video status bits
  localparam int BIT_LEN  = 6;                   // line_length_change_irq_flag
  localparam int BIT_CNT  = 5;                   // line_count_change_irq_flag
  localparam int BIT_OVF  = 4;                   // rx_overflow_irq_flag
  localparam int BIT_PAR  = 2;                   // parity_error_irq_flag
  localparam int BIT_PASS = 1;                   // port_valid_change_irq_flag
  localparam int BIT_LOCK = 0;                   // lock_change_irq_flag
  localparam logic [7:0] VID_MASK      = 8'h77;  // implemented video bits
  localparam logic [7:0] VID_STS1_CLR  = 8'h07;  // cleared by reading link_status_one
  localparam logic [7:0] VID_STS2_CLR  = 8'h70;  // cleared by reading link_status_two

  // ============================================================
  // forward gpio status layout
  localparam int GPIO_FLAG_LSB = 4;              // edge flags in bits 7:4
  localparam int GPIO_LVL_LSB  = 0;              // live levels in bits 3:0

  typedef logic [PORT_W-1:0] rxp_port_t;

endpackage : rxp_pkg

// File: rxp_gpio_if.sv
`timescale 1ns/1ps
// ============================================================
// carries one port's gpio levels, edge enables and flags
interface rxp_gpio_if;
  import rxp_pkg::*;
  logic [GPIO_N-1:0]   level;    // live forward-channel gpio levels
  logic [2*GPIO_N-1:0] edge_ie;  // rise enable at 2i, fall enable at 2i+1
  logic                clr;      // one-cycle read of the gpio status register
  logic [GPIO_N-1:0]   flags;    // sticky edge flags

  modport ctl  (output level, output edge_ie, output clr, input flags);
  modport edet (input level, input edge_ie, input clr, output flags);
endinterface : rxp_gpio_if

// File: rxp_gpio_edge.sv
`timescale 1ns/1ps
// ============================================================
// edge detector and sticky flags for one port's forward gpios
module rxp_gpio_edge
  import rxp_pkg::*;
(
  input wire logic clk,       // register clock
  input wire logic sys_rst,   // asynchronous reset, active high
  rxp_gpio_if.edet g          // levels, enables, clear and flags
);

  typedef struct packed {
    logic [GPIO_N-1:0] prev;  // level seen one cycle ago
    logic [GPIO_N-1:0] flag;  // sticky edge flags
  } rxp_edge_s;

  rxp_edge_s st_r;            // registered state
  rxp_edge_s st_nxt;          // next state
  logic [GPIO_N-1:0] hit;     // enabled edge this cycle

  // ============================================================
  // edge detect: each direction is gated by its own enable bit
  always_comb begin
    for (int i = 0; i < GPIO_N; i++) begin
      hit[i] = (g.level[i] & ~st_r.prev[i] & g.edge_ie[2*i])
             | (~g.level[i] & st_r.prev[i] & g.edge_ie[2*i+1]);
    end
    st_nxt      = st_r;
    st_nxt.prev = g.level;
    // a new edge wins over the read that clears, so none is lost
    st_nxt.flag = (st_r.flag & ~{GPIO_N{g.clr}}) | hit;
  end

  // ============================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign g.flags = st_r.flag;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rise0_s;
    !g.level[0] ##1 (g.level[0] && g.edge_ie[0]);
  endsequence
  sequence fall0_s;
    g.level[0] ##1 (!g.level[0] && g.edge_ie[1]);
  endsequence

  gpio_rise_a: assert property (rise0_s |=> g.flags[0])
    else $error("gpio rising edge not flagged");
  gpio_fall_a: assert property (fall0_s |=> g.flags[0])
    else $error("gpio falling edge not flagged");
  gpio_clear_a: assert property (g.clr && hit == '0 |=> g.flags == '0)
    else $error("gpio flags not cleared by read");
  gpio_hold_a: assert property (g.flags[3] && !g.clr |=> g.flags[3])
    else $error("gpio flag lost without read");
  gpio_quiet_a: assert property (g.edge_ie == '0 && g.flags == '0 |=> g.flags == '0)
    else $error("gpio flag set with edges disabled");

endmodule : rxp_gpio_edge

// File: rxp_irq_status.sv
`timescale 1ns/1ps
// Overview of operation
// - bit2 link-error flags encode error, sts2 clears
// - bit1 flags control sequence error, sts1 clears
// - bit0 flags control crc error, sts1 clears
// - video bit6 flags line length change, sts2
// - video bit5 flags line count change, sts2
// - video bit4 flags receive overflow, sts2 clears
// - video bit2 flags parity error, sts1 clears
// - video bit1 flags port-valid change, sts1 clears
// - video bit0 flags lock change, sts1 clears
// - gpio status bits 7:4 flag gpio3..0
// - gpio flags clear on read, then re-arm
// - gpio status bits 3:0 show live levels
// - status per port, chosen by port select
// - link/video flags raise interrupt only when enabled, gpio flags always
// - gpio flags set on enabled rise/fall edges
module rxp_irq_status
  import rxp_pkg::*;
(
  input  wire logic                        clk,                      // register clock
  input  wire logic                        sys_rst,                  // async reset, high
  input  wire logic [7:0]                  reg_addr,                 // register offset
  input  wire logic                        reg_wr,                   // write strobe
  input  wire logic                        reg_rd,                   // read strobe
  input  wire logic [7:0]                  reg_wdata,                // write data
  output logic      [7:0]                  reg_rdata,                // read data
  output logic                             reg_rvalid,               // read data valid
  input  wire logic                        link_status_one_read,     // sts1 read, sel port
  input  wire logic                        link_status_two_read,     // sts2 read, sel port
  input  wire logic [NUM_PORTS-1:0]        encode_error_cause,       // per-port events
  input  wire logic [NUM_PORTS-1:0]        ctrl_sequence_error_cause,
  input  wire logic [NUM_PORTS-1:0]        ctrl_crc_error_cause,
  input  wire logic [NUM_PORTS-1:0]        line_length_change_cause,
  input  wire logic [NUM_PORTS-1:0]        line_count_change_cause,
  input  wire logic [NUM_PORTS-1:0]        rx_overflow_cause,
  input  wire logic [NUM_PORTS-1:0]        parity_error_cause,
  input  wire logic [NUM_PORTS-1:0]        port_valid_change_cause,
  input  wire logic [NUM_PORTS-1:0]        lock_change_cause,
  input  wire logic [NUM_PORTS*GPIO_N-1:0] fwd_gpio_level,           // gpio levels, 4/port
  output logic                             irq                       // device interrupt
);

  // ============================================================
  // state
  typedef struct packed {
    logic [7:0]                 port_sel;  // write enables and read port index
    logic [NUM_PORTS-1:0][7:0]  err_sts;   // port_link_error_irq_status per port
    logic [NUM_PORTS-1:0][7:0]  vid_sts;   // port_video_irq_status per port
    logic [NUM_PORTS-1:0][7:0]  err_en;    // link_error_irq_enable per port
    logic [NUM_PORTS-1:0][7:0]  vid_en;    // video_irq_enable per port
    logic [NUM_PORTS-1:0][7:0]  gpio_ie;   // gpio_edge_irq_enable per port
    logic [7:0]                 rdata;     // read data register
    logic                       rvalid;    // read answer flag
    logic                       irq;       // registered interrupt
  } rxp_top_s;

  rxp_top_s st_r;                               // registered state
  rxp_top_s st_nxt;                             // next state
  rxp_port_t                 rd_port;           // port that reads reach
  logic [NUM_PORTS-1:0]      wr_port;           // ports that writes reach
  logic [NUM_PORTS-1:0]      gpio_clr;          // gpio status read per port
  // a net, since each detector drives its own slice from inside the generate loop
  wire logic [NUM_PORTS-1:0][GPIO_N-1:0] gpio_flags; // edge flags from detectors

  assign rd_port = st_r.port_sel[PSEL_RD_LSB +: PORT_W];
  assign wr_port = st_r.port_sel[PSEL_WR_LSB +: NUM_PORTS];

  // ============================================================
  // gpio edge detectors, one per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    rxp_gpio_if gif ();                                          // per-port carrier
    assign gif.level   = fwd_gpio_level[p*GPIO_N +: GPIO_N];
    assign gif.edge_ie = st_r.gpio_ie[p];
    assign gif.clr     = gpio_clr[p];
    assign gpio_flags[p] = gif.flags;
    rxp_gpio_edge u_edge (
      .clk     (clk),
      .sys_rst (sys_rst),
      .g       (gif.edet)
    );
  end

  // ============================================================
  // next-state logic
  always_comb begin
    logic [7:0] ev_err;   // link-error events of one port
    logic [7:0] ev_vid;   // video events of one port
    logic [7:0] clr_err;  // link-error bits cleared this cycle
    logic [7:0] clr_vid;  // video bits cleared this cycle
    logic       sel;      // this port is the one being read
    logic       any_irq;  // some enabled flag is pending
    ev_err  = '0;
    ev_vid  = '0;
    clr_err = '0;
    clr_vid = '0;
    sel     = 1'b0;
    any_irq = 1'b0;
    st_nxt  = st_r;
    gpio_clr = '0;
    st_nxt.rvalid = 1'b0;

    for (int p = 0; p < NUM_PORTS; p++) begin
      sel = (rd_port == rxp_port_t'(p));
      // event capture, reserved positions never set
      ev_err = '0;
      ev_err[BIT_ENC]  = encode_error_cause[p];
      ev_err[BIT_SEQ]  = ctrl_sequence_error_cause[p];
      ev_err[BIT_CRC]  = ctrl_crc_error_cause[p];
      ev_vid = '0;
      ev_vid[BIT_LEN]  = line_length_change_cause[p];
      ev_vid[BIT_CNT]  = line_count_change_cause[p];
      ev_vid[BIT_OVF]  = rx_overflow_cause[p];
      ev_vid[BIT_PAR]  = parity_error_cause[p];
      ev_vid[BIT_PASS] = port_valid_change_cause[p];
      ev_vid[BIT_LOCK] = lock_change_cause[p];
      // status reads clear only the selected port's copy
      clr_err = '0;
      clr_vid = '0;
      if (sel && link_status_one_read) begin
        clr_err = clr_err | ERR_STS1_CLR;
        clr_vid = clr_vid | VID_STS1_CLR;
      end
      if (sel && link_status_two_read) begin
        clr_err = clr_err | ERR_STS2_CLR;
        clr_vid = clr_vid | VID_STS2_CLR;
      end
      // set beats clear in the same cycle so no event is dropped
      st_nxt.err_sts[p] = ((st_r.err_sts[p] & ~clr_err) | ev_err) & ERR_MASK;
      st_nxt.vid_sts[p] = ((st_r.vid_sts[p] & ~clr_vid) | ev_vid) & VID_MASK;
      // gpio flags clear when the selected port's gpio status is read
      gpio_clr[p] = reg_rd && sel && (reg_addr == ADDR_GPIO_STS);
      // enable writes reach every port whose write-enable bit is set
      if (reg_wr && wr_port[p]) begin
        case (reg_addr)
          ADDR_ERR_EN:  st_nxt.err_en[p]  = reg_wdata & ERR_MASK;
          ADDR_VID_EN:  st_nxt.vid_en[p]  = reg_wdata & VID_MASK;
          ADDR_GPIO_IE: st_nxt.gpio_ie[p] = reg_wdata;
          default: ;                                          // status writes ignored
        endcase
      end
      // interrupt from enabled link-error and video flags, and from any gpio flag
      any_irq = any_irq
              | (|(st_r.err_sts[p] & st_r.err_en[p]))
              | (|(st_r.vid_sts[p] & st_r.vid_en[p]))
              | (|gpio_flags[p]);
    end

    // port-select register
    if (reg_wr && (reg_addr == ADDR_PORT_SEL)) begin
      st_nxt.port_sel = reg_wdata;
    end

    // read path: one-cycle answer, unmapped offsets read zero
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      case (reg_addr)
        ADDR_PORT_SEL: st_nxt.rdata = st_r.port_sel;
        ADDR_ERR_EN:   st_nxt.rdata = st_r.err_en[rd_port];
        ADDR_VID_EN:   st_nxt.rdata = st_r.vid_en[rd_port];
        ADDR_ERR_STS:  st_nxt.rdata = st_r.err_sts[rd_port];
        ADDR_VID_STS:  st_nxt.rdata = st_r.vid_sts[rd_port];
        ADDR_GPIO_STS: begin
          st_nxt.rdata = RST_BYTE;
          st_nxt.rdata[GPIO_FLAG_LSB +: GPIO_N] = gpio_flags[rd_port];
          // live levels are sampled, never latched into a flag
          st_nxt.rdata[GPIO_LVL_LSB +: GPIO_N] =
            fwd_gpio_level[rd_port*GPIO_N +: GPIO_N];
        end
        default:       st_nxt.rdata = RST_BYTE;     // write-only enables read zero too
      endcase
    end
    st_nxt.irq = any_irq;
  end

  // ============================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.port_sel <= RST_PORT_SEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata  = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign irq        = st_r.irq;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sts1_rd0_s;
    link_status_one_read && rd_port == '0;
  endsequence
  sequence sts2_rd0_s;
    link_status_two_read && rd_port == '0;
  endsequence

  enc_set_a: assert property (encode_error_cause[0] |=> st_r.err_sts[0][BIT_ENC])
    else $error("encode error not flagged");
  enc_clear_a: assert property (sts2_rd0_s and !encode_error_cause[0]
      |=> !st_r.err_sts[0][BIT_ENC])
    else $error("encode flag not cleared by sts2 read");
  seq_hold_a: assert property (st_r.err_sts[0][BIT_SEQ] && !link_status_one_read
      |=> st_r.err_sts[0][BIT_SEQ])
    else $error("sequence flag lost without sts1 read");
  crc_clear_a: assert property (sts1_rd0_s and !ctrl_crc_error_cause[0]
      |=> !st_r.err_sts[0][BIT_CRC])
    else $error("crc flag not cleared by sts1 read");
  vid_two_a: assert property (sts2_rd0_s and !line_length_change_cause[0]
      and !line_count_change_cause[0] and !rx_overflow_cause[0]
      |=> (st_r.vid_sts[0] & VID_STS2_CLR) == '0)
    else $error("video sts2 flags not cleared");
  vid_one_a: assert property (sts1_rd0_s and !parity_error_cause[0]
      and !port_valid_change_cause[0] and !lock_change_cause[0]
      |=> (st_r.vid_sts[0] & VID_STS1_CLR) == '0)
    else $error("video sts1 flags not cleared");
  set_wins_a: assert property (lock_change_cause[0] && link_status_one_read
      |=> st_r.vid_sts[0][BIT_LOCK])
    else $error("lock event lost to clear");
  irq_gate_a: assert property (st_r.err_en == '0 && st_r.vid_en == '0
      && gpio_flags == '0 |=> !irq)
    else $error("interrupt raised with nothing enabled");
  irq_raise_a: assert property (st_r.vid_sts[0][BIT_OVF] && st_r.vid_en[0][BIT_OVF]
      |=> irq)
    else $error("enabled flag did not raise interrupt");
  reserved_a: assert property ((st_r.err_sts[0] & ~ERR_MASK) == '0
      && (st_r.vid_sts[0] & ~VID_MASK) == '0)
    else $error("reserved status bit set");
  read_answer_a: assert property (reg_rd && reg_addr == ADDR_ERR_STS
      |=> reg_rvalid && reg_rdata == $past(st_r.err_sts[rd_port]))
    else $error("status read answered wrongly");
  live_level_a: assert property (reg_rd && reg_addr == ADDR_GPIO_STS && rd_port == '0
      |=> reg_rdata[3:0] == $past(fwd_gpio_level[3:0]))
    else $error("gpio live level wrong");

endmodule : rxp_irq_status

// File: rxp_fwd_model.sv
`timescale 1ns/1ps
// ============================================================
// far-side stand-in: link event pulses and forward gpio levels
module rxp_fwd_model
  import rxp_pkg::*;
(
  input  wire logic                   clk,    // register clock
  output logic [8:0][NUM_PORTS-1:0]   cause,  // event pulses, one row per cause
  output logic [NUM_PORTS*GPIO_N-1:0] gpio    // gpio levels, four per port
);
  // idle at time zero so no unknown reaches the block
  initial begin
    cause = '0;
    gpio  = '0;
  end

  // one-cycle pulse; a held level would re-set the flag every cycle
  task automatic fire(input int k, input int p);
    @(posedge clk);
    cause[k][p] <= 1'b1;
    @(posedge clk);
    cause[k][p] <= 1'b0;
  endtask

  // levels move only just after an edge, like a synchronous far side
  task automatic set_gpio(input logic [NUM_PORTS*GPIO_N-1:0] v);
    @(posedge clk);
    gpio <= v;
  endtask
endmodule // rxp_fwd_model

// File: rxp_irq_status_tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the per-port interrupt status block
module rxp_irq_status_tb
  import rxp_pkg::*;
;
  logic                          clk       = 1'b0;  // 125 MHz clock
  logic                          sys_rst   = 1'b1;  // held for 20 cycles
  logic [7:0]                    reg_addr  = 8'h00; // register offset
  logic                          reg_wr    = 1'b0;  // write strobe
  logic                          reg_rd    = 1'b0;  // read strobe
  logic [7:0]                    reg_wdata = 8'h00; // write data
  logic                          sts1_rd   = 1'b0;  // link_status_one read pulse
  logic                          sts2_rd   = 1'b0;  // link_status_two read pulse
  logic [7:0]                    reg_rdata;         // read answer
  logic                          reg_rvalid;        // read answer valid
  logic                          irq;               // device interrupt
  logic [8:0][NUM_PORTS-1:0]     cause;             // from the far-side model
  logic [NUM_PORTS*GPIO_N-1:0]   gpio;              // from the far-side model
  int                            error_cnt = 0;     // mismatches
  int                            cmp_count = 0;     // comparisons made
  int                            cyc       = 0;     // cycles run, for the hang guard
  int                            seed      = 32'h9E5C;
  logic [7:0]                    exp_q[$];          // expected read answers, oldest first
  // status bit of each cause, in the model's row order
  logic [7:0] ev_bit [9] = '{8'h04, 8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
  logic [8:0] ev_two     = 9'h039;                  // causes cleared by link_status_two

  always #4 clk = ~clk;

  rxp_fwd_model fwd (.clk(clk), .cause(cause), .gpio(gpio));

  rxp_irq_status dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .link_status_one_read(sts1_rd), .link_status_two_read(sts2_rd),
    .encode_error_cause(cause[0]), .ctrl_sequence_error_cause(cause[1]),
    .ctrl_crc_error_cause(cause[2]), .line_length_change_cause(cause[3]),
    .line_count_change_cause(cause[4]), .rx_overflow_cause(cause[5]),
    .parity_error_cause(cause[6]), .port_valid_change_cause(cause[7]),
    .lock_change_cause(cause[8]), .fwd_gpio_level(gpio), .irq(irq));

  // ============================================================
  // closing report, reached from the main sequence or the hang guard
  task automatic summarize;
    // a read that never got its answer leaves a note behind
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("[ERR] %0t %0d read answers missing", $time, exp_q.size());
    end
    $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // compare of a read answer
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // compare of the interrupt, two edges after the cause so the register has landed
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    cmp_count++;
    if (irq !== e) begin
      error_cnt++;
      $display("[ERR] %0t irq %b expected %b", $time, irq, e);
    end
  endtask

  // ============================================================
  // strobe port: one-cycle strobes, held up to the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // the answer comes one cycle later, so the note is queued here
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // read pulse of link status one or two for the selected port
  task automatic clr(input logic two);
    @(posedge clk);
    if (two) begin
      sts2_rd <= 1'b1;
    end else begin
      sts1_rd <= 1'b1;
    end
    @(posedge clk);
    sts1_rd <= 1'b0;
    sts2_rd <= 1'b0;
  endtask

  // ============================================================
  // watcher: every answer takes the oldest note off the queue
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t answer without a read", $time);
      end else begin
        chk_byte(reg_rdata, exp_q.pop_front());
      end
    end
  end

  // hang guard; the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    int                          p;
    logic [7:0]                  a;
    logic [7:0]                  b;
    logic [NUM_PORTS*GPIO_N-1:0] g;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_PORT_SEL, RST_PORT_SEL);
    rd(8'h00, 8'h00);
    rd(ADDR_GPIO_IE, 8'h00);
    for (int q = 0; q < NUM_PORTS; q++) begin
      wr(ADDR_PORT_SEL, 8'(q << PSEL_RD_LSB));
      rd(ADDR_ERR_STS, RST_BYTE);
      rd(ADDR_VID_STS, RST_BYTE);
      rd(ADDR_GPIO_STS, RST_BYTE);
    end
    // every cause on a random port: flag, gating, port copy, wrong and right clear
    for (int k = 0; k < 9; k++) begin
      p = $unsigned($random(seed)) % NUM_PORTS;
      a = (k < 3) ? ADDR_ERR_STS : ADDR_VID_STS;
      b = ev_bit[k];
      wr(ADDR_PORT_SEL, 8'((p << PSEL_RD_LSB) | 8'h0F));
      wr(ADDR_ERR_EN, 8'h00);
      wr(ADDR_VID_EN, 8'h00);
      fwd.fire(k, p);
      wr(a, 8'hFF);
      rd(a, b);
      chk_irq(1'b0);
      wr(a - 8'h02, b);
      chk_irq(1'b1);
      wr(ADDR_PORT_SEL, 8'(((p ^ 1) << PSEL_RD_LSB) | 8'h0F));
      rd(a, 8'h00);
      wr(ADDR_PORT_SEL, 8'((p << PSEL_RD_LSB) | 8'h0F));
      clr(!ev_two[k]);
      rd(a, b);
      clr(ev_two[k]);
      rd(a, 8'h00);
      chk_irq(1'b0);
    end
    // gpio: rise on 0, fall on 1, both on 2, none on 3; other ports random, unarmed
    p = $unsigned($random(seed)) % NUM_PORTS;
    wr(ADDR_PORT_SEL, 8'((p << PSEL_RD_LSB) | (1 << p)));
    wr(ADDR_GPIO_IE, 8'h39);
    g = (NUM_PORTS*GPIO_N)'($random(seed));
    g[p*GPIO_N +: GPIO_N] = 4'hF;
    fwd.set_gpio(g);
    chk_irq(1'b1);
    rd(ADDR_GPIO_STS, 8'h5F);
    rd(ADDR_GPIO_STS, 8'h0F);
    chk_irq(1'b0);
    g[p*GPIO_N +: GPIO_N] = 4'h0;
    fwd.set_gpio(g);
    rd(ADDR_GPIO_STS, 8'h60);
    g[p*GPIO_N +: GPIO_N] = 4'hF;
    fwd.set_gpio(g);
    rd(ADDR_GPIO_STS, 8'h5F);
    rd(ADDR_GPIO_STS, 8'h0F);
    // set beats clear: lock event and sts1 read on port 0 in one cycle
    wr(ADDR_PORT_SEL, 8'h0F);
    fork
      fwd.fire(8, 0);
      clr(1'b0);
    join
    rd(ADDR_VID_STS, 8'h01);
    chk_irq(1'b1);
    clr(1'b0);
    rd(ADDR_VID_STS, 8'h00);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // rxp_irq_status_tb
